// File: hw/pdl_ctrl.sv
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module pdl_ctrl #(
	parameter int LOSS100_CYC = pdl_pkg::LOSS100_US * 1000 / pdl_pkg::CLK_NS,
	parameter int LOSS1G_CYC = pdl_pkg::LOSS1G_US * 1000 / pdl_pkg::CLK_NS
) (
	input wire logic	ref_clk,	// 200 MHz reference clock.
	input wire logic	nrst,		// Async reset, active low.
	input wire logic [11:0]	awaddr,		// AXI write address.
	input wire logic	awvalid,	// AXI write address valid.
	output logic		awready,	// AXI write address ready.
	input wire logic [31:0]	wdata,		// AXI write data.
	input wire logic [3:0]	wstrb,		// AXI write strobes.
	input wire logic	wvalid,		// AXI write data valid.
	output logic		wready,		// AXI write data ready.
	output logic [1:0]	bresp,		// AXI write response.
	output logic		bvalid,		// AXI write response valid.
	input wire logic	bready,		// AXI write response ready.
	input wire logic [11:0]	araddr,		// AXI read address.
	input wire logic	arvalid,	// AXI read address valid.
	output logic		arready,	// AXI read address ready.
	output logic [31:0]	rdata,		// AXI read data.
	output logic [1:0]	rresp,		// AXI read response.
	output logic		rvalid,		// AXI read valid.
	input wire logic	rready,		// AXI read ready.
	input wire logic	speed1000,	// Link runs at 1000M.
	input wire logic	pcsLinkOk,	// PCS reports link good.
	input wire logic	descrLock,	// Descrambler in sync.
	input wire logic	rxErr,		// Receive error seen.
	input wire logic	mlt3Err,	// MLT-3 coding error seen.
	input wire logic	mseBad,		// Mean squared error too high.
	input wire logic [15:0]	lineSample,	// Line signal magnitude.
	input wire logic	echoValid,	// Echo detected this cycle.
	input wire logic	echoCross,	// Echo is a cross fault.
	input wire logic [15:0]	echoTime,	// Echo arrival time.
	input wire logic [15:0]	echoAmp,	// Echo amplitude.
	output logic [3:0]	tdrPulse,	// Test pulse, one bit a pair.
	output logic		diagBusy,	// Diagnostic run under way.
	output logic		linkUp,		// Link declared up.
	output logic		linkDrop,	// Link loss event pulse.
	output logic		energyPresent,	// Energy detected on line.
	output logic [2:0]	testMode,	// Active transmit test mode.
	output logic [1:0]	fastLinkModes,	// Fast link-detect modes.
	output logic [15:0]	frameLimit,	// Longest frame in bytes.
	output pdl_pkg::pdl_clksrc_t clkOutSel,	// Clock output source.
	output logic [2:0]	clkOutChan,	// Clock channel at 1000M.
	output logic		clkOutOe	// Clock output pin enable.
);
	import pdl_pkg::*;

	typedef enum logic [2:0] {D_IDLE, D_WAIT, D_PULSE, D_LISTEN, D_NEXT} pdl_dst_t;

	logic [15:0]	baseCfg_q, fastCfg_q, tmSetup_q, coSetup_q, ioCfg_q;
	logic [15:0]	edListen_q, jumbo_q;
	logic [31:0]	edThr_q;
	logic [4:0]	diagSel_q;
	logic		bvalid_q, rvalid_q, done_q;
	logic [1:0]	bresp_q, rresp_q;
	logic [31:0]	rdata_q, rdMux;
	logic		rdHit, wrHit, wrGo, rdGo, startReq;
	logic [9:0]	wIdx, rIdx;
	pdl_dst_t	dState_q;
	logic [1:0]	pair_q;
	logic [10:0]	tmr_q;
	logic [NPAIR-1:0][NREFL-1:0][31:0] refl_q;
	logic [NPAIR-1:0][31:0]	cross_q;
	logic [NPAIR-1:0][2:0]	cnt_q;
	logic [NPAIR-1:0]	crossV_q;
	logic [2:0]	lim;
	logic		lineQuiet;
	logic		linkUp_q, linkDrop_q, fastOn, bad, expire;
	logic [4:0]	crit;
	logic [17:0]	lossCnt_q, win;
	logic [2:0]	tmField, testMode_q;
	logic		tmAct, coOpen;
	pdl_clksrc_t	clkOutSel_q;
	logic [2:0]	clkOutChan_q;
	logic		clkOutOe_q;
	logic [1:0]	fastModes_q;
	pdl_ed_if	ed ();

	// Applies AXI byte strobes to a stored word.
	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] nw, input logic [3:0] stb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (stb[i]) r[8*i +: 8] = nw[8*i +: 8];
		end
		return r;
	endfunction : merge

	// Word index of a byte address; the low two bits are ignored.
	function automatic logic [9:0] regIdx(input logic [11:0] a);
		return a[11:2];
	endfunction : regIdx

	////////////////////////////////////////////////////////////////////
	// AXI4-Lite write side: address and data are taken together.
	assign wIdx = regIdx(awaddr);
	assign wrGo = awvalid && wvalid && !bvalid_q;
	assign awready = wrGo;
	assign wready = wrGo;
	assign wrHit = wIdx inside {IDX_BASE, IDX_FAST, IDX_TMS, IDX_COS,
		IDX_IO, IDX_DCTL, IDX_DSEL, IDX_DRES, IDX_EDTH, IDX_EDLP,
		IDX_STAT, IDX_JMB};
	assign startReq = wrGo && wIdx == IDX_DCTL && wstrb[0] && wdata[0];
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OK;
		end else if (wrGo) begin
			bvalid_q <= 1'b1;
			bresp_q <= wrHit ? RESP_OK : RESP_ERR;
		end else if (bready) begin
			bvalid_q <= 1'b0;
		end
	end
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;

	// Configuration registers; reads of status words have no effect.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			baseCfg_q <= CFG_RST;
			fastCfg_q <= CFG_RST;
			tmSetup_q <= CFG_RST;
			coSetup_q <= CFG_RST;
			ioCfg_q <= CFG_RST;
			diagSel_q <= 5'h00;
			edThr_q <= EDTH_RST;
			edListen_q <= EDLP_RST;
			jumbo_q <= JUMBO_RST;
		end else if (wrGo) begin
			unique case (wIdx)
			IDX_BASE: baseCfg_q <= 16'(merge({16'h0, baseCfg_q}, wdata, wstrb));
			IDX_FAST: fastCfg_q <= 16'(merge({16'h0, fastCfg_q}, wdata, wstrb));
			IDX_TMS: tmSetup_q <= 16'(merge({16'h0, tmSetup_q}, wdata, wstrb));
			IDX_COS: coSetup_q <= 16'(merge({16'h0, coSetup_q}, wdata, wstrb));
			IDX_IO: ioCfg_q <= 16'(merge({16'h0, ioCfg_q}, wdata, wstrb));
			IDX_DSEL: diagSel_q <= 5'(merge({27'h0, diagSel_q}, wdata, wstrb));
			IDX_EDTH: edThr_q <= merge(edThr_q, wdata, wstrb);
			IDX_EDLP: edListen_q <= 16'(merge({16'h0, edListen_q}, wdata, wstrb));
			IDX_JMB: jumbo_q <= 16'(merge({16'h0, jumbo_q}, wdata, wstrb));
			default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// AXI4-Lite read side; one read in flight, data from a flip-flop.
	assign rIdx = regIdx(araddr);
	assign rdGo = arvalid && !rvalid_q;
	assign arready = !rvalid_q;
	always_comb begin
		rdHit = 1'b1;
		rdMux = 32'h0000_0000;
		unique case (rIdx)
		IDX_BASE: rdMux = {16'h0, baseCfg_q};
		IDX_FAST: rdMux = {16'h0, fastCfg_q};
		IDX_TMS: rdMux = {16'h0, tmSetup_q};
		IDX_COS: rdMux = {16'h0, coSetup_q};
		IDX_IO: rdMux = {16'h0, ioCfg_q};
		IDX_DCTL: rdMux = {24'h0, 1'b0, cnt_q[diagSel_q[1:0]],
			crossV_q[diagSel_q[1:0]], done_q, diagBusy, 1'b0};
		IDX_DSEL: rdMux = {27'h0, diagSel_q};
		IDX_DRES: begin
			// Slot 5 holds the cross-fault location of the pair.
			if (diagSel_q[4:2] == 3'h5)
				rdMux = cross_q[diagSel_q[1:0]];
			else if (diagSel_q[4:2] < 3'h5)
				rdMux = refl_q[diagSel_q[1:0]][diagSel_q[4:2]];
		end
		IDX_EDTH: rdMux = edThr_q;
		IDX_EDLP: rdMux = {16'h0, edListen_q};
		IDX_STAT: rdMux = {28'h0, testMode_q != 3'h0, ed.present,
			linkUp_q, diagBusy};
		IDX_JMB: rdMux = {16'h0, jumbo_q};
		default: rdHit = 1'b0;
		endcase
	end
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= RESP_OK;
		end else if (rdGo) begin
			rvalid_q <= 1'b1;
			rdata_q <= rdMux;
			rresp_q <= rdHit ? RESP_OK : RESP_ERR;
		end else if (rready) begin
			rvalid_q <= 1'b0;
		end
	end
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;

	////////////////////////////////////////////////////////////////////
	// Energy detector settings travel on the carrier.
	assign ed.sample = lineSample;
	assign ed.onThr = edThr_q[15:0];
	assign ed.offThr = edThr_q[31:16];
	assign ed.listen = edListen_q;
	pdl_energy_det u_ed (
		.ref_clk	(ref_clk),
		.nrst		(nrst),
		.ed		(ed)
	);
	assign energyPresent = ed.present;

	////////////////////////////////////////////////////////////////////
	// Link-loss window; fast mode trades robustness for reaction time.
	assign fastOn = fastCfg_q[FAST_EN_BIT];
	assign crit = {~ed.present, mseBad, mlt3Err, rxErr, ~descrLock};
	assign bad = fastOn ? |(crit & fastCfg_q[4:0])
		: (~descrLock | ~ed.present);
	assign win = fastOn ? 18'(FAST_CYC)
		: (speed1000 ? 18'(LOSS1G_CYC) : 18'(LOSS100_CYC));
	assign expire = linkUp_q && bad && lossCnt_q == win - 18'h1;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) lossCnt_q <= 18'h0;
		else if (linkUp_q && bad && !expire) lossCnt_q <= lossCnt_q + 18'h1;
		else lossCnt_q <= 18'h0;
	end
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			linkUp_q <= 1'b0;
			linkDrop_q <= 1'b0;
		end else begin
			linkUp_q <= linkUp_q ? (pcsLinkOk && !expire)
				: (pcsLinkOk && !bad);
			linkDrop_q <= linkUp_q && (!pcsLinkOk || expire);
		end
	end
	assign linkUp = linkUp_q;
	assign linkDrop = linkDrop_q;

	// Fast link-detect modes depend on the link speed.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) fastModes_q <= 2'h0;
		else fastModes_q <= speed1000 ? fastCfg_q[9:8] : fastCfg_q[11:10];
	end
	assign fastLinkModes = fastModes_q;
	assign frameLimit = jumbo_q;

	////////////////////////////////////////////////////////////////////
	// Reflectometry sequencer: wait quiet, pulse each pair, listen.
	assign lineQuiet = !linkUp_q && !ed.present;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			dState_q <= D_IDLE;
			pair_q <= 2'h0;
			tmr_q <= 11'h0;
		end else begin
			unique case (dState_q)
			D_IDLE: if (startReq || (linkDrop_q
					&& baseCfg_q[AUTO_DIAG_BIT]))
				dState_q <= D_WAIT;
			D_WAIT: if (lineQuiet) begin
				dState_q <= D_PULSE;
				pair_q <= 2'h0;
				tmr_q <= 11'(PULSE_CYC - 1);
			end
			D_PULSE: if (tmr_q == 11'h0) begin
				dState_q <= D_LISTEN;
				tmr_q <= 11'(LISTEN_CYC - 1);
			end else begin
				tmr_q <= tmr_q - 11'h1;
			end
			D_LISTEN: if (tmr_q == 11'h0) dState_q <= D_NEXT;
				else tmr_q <= tmr_q - 11'h1;
			D_NEXT: if (pair_q == 2'(NPAIR - 1)) begin
				dState_q <= D_IDLE;
			end else begin
				pair_q <= pair_q + 2'h1;
				tmr_q <= 11'(PULSE_CYC - 1);
				dState_q <= D_PULSE;
			end
			endcase
		end
	end
	assign tdrPulse = (dState_q == D_PULSE) ? 4'h1 << pair_q : 4'h0;
	assign diagBusy = dState_q != D_IDLE;

	// Done flag: set at run end, cleared by the next start.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) done_q <= 1'b0;
		else if (dState_q == D_NEXT && pair_q == 2'(NPAIR - 1)) done_q <= 1'b1;
		else if (dState_q == D_WAIT && lineQuiet) done_q <= 1'b0;
	end

	// Echo capture; results are cleared only when a run starts.
	assign lim = crossV_q[pair_q] ? 3'(NREFL - 1) : 3'(NREFL);
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			refl_q <= '0;
			cross_q <= '0;
			cnt_q <= '0;
			crossV_q <= '0;
		end else if (dState_q == D_WAIT && lineQuiet) begin
			cnt_q <= '0;
			crossV_q <= '0;
		end else if (dState_q == D_LISTEN && echoValid) begin
			if (echoCross) begin
				if (!crossV_q[pair_q]) begin
					cross_q[pair_q] <= {echoAmp, echoTime};
					crossV_q[pair_q] <= 1'b1;
					if (cnt_q[pair_q] == 3'(NREFL))
						cnt_q[pair_q] <= 3'(NREFL - 1);
				end
			end else if (cnt_q[pair_q] < lim) begin
				refl_q[pair_q][cnt_q[pair_q]] <= {echoAmp, echoTime};
				cnt_q[pair_q] <= cnt_q[pair_q] + 3'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Test modes need the unlock word; bad codes fall back to normal.
	assign tmField = baseCfg_q[TM_LSB +: 3];
	assign tmAct = tmSetup_q == TEST_UNLOCK && tmField != 3'h0
		&& tmField <= TM_MAX;
	assign coOpen = coSetup_q == CLK_UNLOCK;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) testMode_q <= 3'h0;
		else testMode_q <= tmAct ? tmField : 3'h0;
	end
	assign testMode = testMode_q;

	// Clock output select; the mux itself sits in the pad ring.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			clkOutSel_q <= CO_XTAL;
			clkOutChan_q <= 3'h0;
			clkOutOe_q <= 1'b0;
		end else begin
			if (tmAct) clkOutSel_q <= CO_TX;
			else if (coOpen) clkOutSel_q <= pdl_clksrc_t'(ioCfg_q[1:0]);
			else clkOutSel_q <= CO_XTAL;
			clkOutChan_q <= (coOpen && speed1000) ? ioCfg_q[4:2] : 3'h0;
			clkOutOe_q <= !ioCfg_q[CO_DIS_BIT];
		end
	end
	assign clkOutSel = clkOutSel_q;
	assign clkOutChan = clkOutChan_q;
	assign clkOutOe = clkOutOe_q;

	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	sequence sPulseStart;
		$rose(dState_q == D_PULSE) or (dState_q == D_NEXT ##1 dState_q == D_PULSE);
	endsequence
	a_pulse_width: assert property (sPulseStart |-> (tdrPulse != 4'h0)[*4] ##1 tdrPulse == 4'h0)
		else $error("test pulse width wrong");
	a_refl_cap: assert property (dState_q == D_LISTEN && echoValid && !echoCross && cnt_q[pair_q] == 3'h5 |=> cnt_q[$past(pair_q)] == 3'h5)
		else $error("sixth reflection stored");
	a_cross_cap: assert property (crossV_q[pair_q] |-> cnt_q[pair_q] <= 3'h4)
		else $error("too many reflections with cross fault");
	a_quiet_start: assert property (dState_q == D_WAIT && !lineQuiet |=> dState_q != D_PULSE)
		else $error("run started on busy line");
	a_auto_diag: assert property (linkDrop_q && baseCfg_q[7] && dState_q == D_IDLE |=> dState_q == D_WAIT ##[1:3] dState_q != D_IDLE)
		else $error("auto diagnostic not started");
	a_loss_window: assert property ($fell(linkUp_q) && $past(pcsLinkOk) |-> $past(lossCnt_q) == $past(win) - 18'h1)
		else $error("link dropped before window ended");
	a_fast_bound: assert property (fastOn && $past(fastOn) |-> lossCnt_q < 18'd2000)
		else $error("fast window exceeded");
	a_fast_crit: assert property (fastOn && linkUp_q && (crit & fastCfg_q[4:0]) == 5'h0 |=> lossCnt_q == 18'h0)
		else $error("disabled criterion counted");
	a_fast_modes: assert property (!speed1000 |=> fastLinkModes == $past(fastCfg_q[11:10]))
		else $error("wrong fast link modes");
	a_test_lock: assert property (tmSetup_q != 16'h1002 |=> testMode == 3'h0)
		else $error("test mode without unlock");
	a_test_clk: assert property (testMode != 3'h0 |-> clkOutSel == CO_TX)
		else $error("test mode without tx clock");
	a_clk_default: assert property (!tmAct && coSetup_q != 16'h0010 |=> clkOutSel == CO_XTAL)
		else $error("clock source changed while locked");
	a_clk_off: assert property (ioCfg_q[5] |=> !clkOutOe)
		else $error("clock pin driven while disabled");
	a_results_hold: assert property (dState_q == D_IDLE |=> $stable(cnt_q) && $stable(refl_q))
		else $error("results changed outside a run");
endmodule : pdl_ctrl
`default_nettype wire

// File: hw/pdl_ed_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pdl_ed_if;
	logic [15:0]	sample;
	logic [15:0]	onThr;
	logic [15:0]	offThr;
	logic [15:0]	listen;
	logic		present;
	modport ctrl (output sample, onThr, offThr, listen, input present);
	modport det (input sample, onThr, offThr, listen, output present);
endinterface : pdl_ed_if
`default_nettype wire

// File: hw/pdl_energy_det.sv
`timescale 1ns/10ps
`default_nettype none
module pdl_energy_det #(
	parameter int SHIFT = 3	// IIR pole: y += (x - y) / 2**SHIFT.
) (
	input wire logic	ref_clk,	// Reference clock.
	input wire logic	nrst,		// Async reset, active low.
	pdl_ed_if.det		ed		// Energy detector carrier.
);
	logic [15:0]	filt_q;
	logic [15:0]	hold_q;
	logic		present_q;
	logic [16:0]	diff;
	logic [16:0]	step;
	logic		want;

	////////////////////////////////////////////////////////////////////
	// First-order IIR on the sample magnitude; cheap and no multiplier.
	assign diff = {1'b0, ed.sample} - {1'b0, filt_q};
	assign step = 17'($signed(diff) >>> SHIFT);
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) filt_q <= 16'h0000;
		else filt_q <= filt_q + step[15:0];
	end

	////////////////////////////////////////////////////////////////////
	// Two thresholds give hysteresis; the listen time debounces edges.
	assign want = present_q ? (filt_q >= ed.offThr) : (filt_q > ed.onThr);
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			hold_q <= 16'h0000;
			present_q <= 1'b0;
		end else if (want == present_q) begin
			hold_q <= 16'h0000;
		end else if (hold_q >= ed.listen) begin
			hold_q <= 16'h0000;
			present_q <= want;
		end else begin
			hold_q <= hold_q + 16'h0001;
		end
	end
	assign ed.present = present_q;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	a_ed_hyst_hold: assert property (
		present_q && filt_q >= ed.offThr |=> present_q)
		else $error("energy indication dropped above off threshold");
endmodule : pdl_energy_det
`default_nettype wire

// File: hw/pdl_pkg.sv
package pdl_pkg;
	// Timing at a 200 MHz reference clock.
	localparam int CLK_NS		= 5;
	localparam int LOSS100_US	= 1000;
	localparam int LOSS1G_US	= 500;
	localparam int FAST_US		= 10;
	localparam int FAST_CYC		= FAST_US * 1000 / CLK_NS;
	localparam int PULSE_CYC	= 4;
	localparam int LISTEN_CYC	= 1024;
	localparam int NPAIR		= 4;
	localparam int NREFL		= 5;
	// Register indexes; the byte address is four times the index.
	localparam logic [9:0] IDX_BASE	= 10'h009;
	localparam logic [9:0] IDX_FAST	= 10'h01E;
	localparam logic [9:0] IDX_TMS	= 10'h0A8;
	localparam logic [9:0] IDX_COS	= 10'h0C6;
	localparam logic [9:0] IDX_IO	= 10'h170;
	localparam logic [9:0] IDX_DCTL	= 10'h180;
	localparam logic [9:0] IDX_DSEL	= 10'h181;
	localparam logic [9:0] IDX_DRES	= 10'h182;
	localparam logic [9:0] IDX_EDTH	= 10'h183;
	localparam logic [9:0] IDX_EDLP	= 10'h184;
	localparam logic [9:0] IDX_STAT	= 10'h185;
	localparam logic [9:0] IDX_JMB	= 10'h186;
	// Field positions and magic values.
	localparam int AUTO_DIAG_BIT	= 7;
	localparam int TM_LSB		= 13;
	localparam int FAST_EN_BIT	= 5;
	localparam int CO_DIS_BIT	= 5;
	localparam logic [15:0] TEST_UNLOCK	= 16'h1002;
	localparam logic [15:0] CLK_UNLOCK	= 16'h0010;
	localparam logic [2:0] TM_MAX	= 3'h4;
	// Values after reset.
	localparam logic [15:0] CFG_RST		= 16'h0000;
	localparam logic [15:0] JUMBO_RST	= 16'h3400;
	localparam logic [31:0] EDTH_RST	= 32'h0040_0080;
	localparam logic [15:0] EDLP_RST	= 16'h0010;
	localparam logic [1:0] RESP_OK	= 2'h0;
	localparam logic [1:0] RESP_ERR	= 2'h2;
	typedef enum logic [1:0] {CO_XTAL, CO_RX125, CO_RX25, CO_TX} pdl_clksrc_t;
endpackage : pdl_pkg

// File: verification/pdl_cable_model.sv
`timescale 1ns/10ps
`default_nettype none
// Far end of the cable: echoes each test pulse and makes line energy.
module pdl_cable_model (
	input wire logic	clk,	// Reference clock.
	input wire logic [3:0]	pulse,	// Test pulses from the block.
	input wire logic	live,	// Far end is talking.
	input wire logic	xfault,	// Pairs are crossed on the cable.
	output logic		echoV,	// Echo strobe.
	output logic		echoX,	// Echo is a cross fault.
	output logic [15:0]	echoT,	// Echo arrival time.
	output logic [15:0]	lvl,	// Line magnitude.
	output int		pulses	// Pulse starts seen.
);
	logic [3:0]	prev = 4'h0;
	int		t = 0;
	initial pulses = 0;
	initial echoV = 1'h0;
	initial echoX = 1'h0;
	// A quiet far end leaves no energy on the line.
	assign lvl = live ? 16'hFFFF : 16'h0000;
	assign echoT = 16'(t);
	// Seven echoes per pulse, so the block must drop two of them.
	always @(posedge clk) begin
		prev <= pulse;
		if (pulse != 4'h0 && prev == 4'h0) begin
			pulses <= pulses + 1;
		end
		t <= (pulse != 4'h0) ? 1 : (t != 0 && t < 200) ? t + 1 : 0;
		echoV <= (t % 20 == 10) && t < 150;
		// With crossed pairs the third echo is the cross fault.
		echoX <= xfault && t == 50;
	end
endmodule : pdl_cable_model
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import pdl_pkg::*;
	logic ref_clk = 1'h0, nrst = 1'h0, live = 1'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic arvalid = 1'h0, rready = 1'h0, rxErr = 1'h0;
	logic pcsLinkOk = 1'h0, descrLock = 1'h0, speed1000 = 1'h1;
	logic xfault = 1'h0, echoCross;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0, rdata, rv;
	logic awready, wready, bvalid, arready, rvalid, echoValid, diagBusy;
	logic linkUp, linkDrop, energyPresent, clkOutOe;
	logic [1:0] bresp, rresp, fastLinkModes, rs;
	logic [15:0] lineSample, echoTime, frameLimit;
	logic [3:0] tdrPulse;
	logic [2:0] testMode, clkOutChan;
	pdl_clksrc_t clkOutSel;
	int errorCnt = 0, comparisons = 0, pulses, n, p0;
	// Short loss windows keep the run brief.
	pdl_ctrl #(.LOSS100_CYC(50), .LOSS1G_CYC(30)) dut (.wstrb(4'hF),
		.mlt3Err(1'h0), .mseBad(1'h0), .echoAmp(~echoTime), .*);
	pdl_cable_model cab (.clk(ref_clk), .pulse(tdrPulse), .live, .xfault,
		.echoV(echoValid), .echoX(echoCross), .echoT(echoTime),
		.lvl(lineSample), .pulses);
	always #2.5 ref_clk = ~ref_clk;
	task automatic ck(input logic ok, input string m);
		comparisons++;
		if (ok !== 1'h1) begin
			errorCnt++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask : ck
	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk);
	endtask : cyc
	// Address and data go out together; the response is awaited.
	task automatic wr(input logic [9:0] i, input logic [31:0] d);
		awaddr <= {i, 2'h0};
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		do @(posedge ref_clk); while (awready !== 1'h1);
		awvalid <= 1'h0;
		wvalid <= 1'h0;
		bready <= 1'h1;
		do @(posedge ref_clk); while (bvalid !== 1'h1);
		rs = bresp;
		bready <= 1'h0;
	endtask : wr
	task automatic rd(input logic [9:0] i);
		araddr <= {i, 2'h0};
		arvalid <= 1'h1;
		do @(posedge ref_clk); while (arready !== 1'h1);
		arvalid <= 1'h0;
		rready <= 1'h1;
		do @(posedge ref_clk); while (rvalid !== 1'h1);
		rv = rdata;
		rs = rresp;
		rready <= 1'h0;
	endtask : rd
	task automatic results;
		$display("Counts: %0d checks, %0d failures", comparisons, errorCnt);
		if (errorCnt == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : results
	task automatic t_reset;
		ck(clkOutSel === CO_XTAL && clkOutOe === 1'h1, "clock default");
		rd(IDX_JMB);
		ck(rv === 32'h0000_3400, "frame limit");
		ck(frameLimit === JUMBO_RST, "frame limit pin");
		wr(IDX_JMB, 32'h0000_0600);
		ck(frameLimit === 16'h0600, "frame limit write");
		rd(IDX_EDTH);
		ck(rv === EDTH_RST, "energy thresholds");
		rd(10'h3FF);
		ck(rs === RESP_ERR, "unmapped read");
		$display("test reset done");
	endtask : t_reset
	task automatic t_test;
		wr(IDX_BASE, 32'h0000_2000);
		cyc(2);
		ck(testMode === 3'h0, "mode without setup");
		wr(IDX_TMS, 32'h0000_1002);
		// Code 5 is not a test mode and must fall back to normal.
		for (int m = 1; m <= 5; m++) begin
			wr(IDX_BASE, 32'(m) << TM_LSB);
			cyc(2);
			ck(testMode === 3'(m % 5), "mode");
			ck(clkOutSel === (m < 5 ? CO_TX : CO_XTAL), "tx clock");
		end
		wr(IDX_BASE, 32'h0000_0000);
		$display("test modes done");
	endtask : t_test
	task automatic t_clk;
		wr(IDX_IO, 32'h0000_0001);
		cyc(2);
		ck(clkOutSel === CO_XTAL, "select while locked");
		wr(IDX_COS, 32'h0000_0010);
		for (int s = 1; s <= 3; s++) begin
			wr(IDX_IO, 32'(s) | 32'h0000_0014);
			cyc(2);
			ck(clkOutSel === pdl_clksrc_t'(s), "source");
			ck(clkOutChan === 3'h5, "channel");
		end
		speed1000 <= 1'h0;
		cyc(2);
		ck(clkOutChan === 3'h0, "channel at 100M");
		speed1000 <= 1'h1;
		wr(IDX_IO, 32'h0000_0020);
		cyc(2);
		ck(clkOutOe === 1'h0, "disable");
		wr(IDX_IO, 32'h0000_0000);
		$display("test clock done");
	endtask : t_clk
	// Waits for a diagnostic run to end, at most 6000 cycles.
	task automatic waitDiag;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (diagBusy !== 1'h0 && n < 6000);
		ck(n < 6000, "run ends");
	endtask : waitDiag
	task automatic t_diag;
		p0 = pulses;
		wr(IDX_DCTL, 32'h0000_0001);
		waitDiag();
		ck(pulses - p0 == 4, "four pairs pulsed");
		for (int p = 0; p < 4; p++) begin
			wr(IDX_DSEL, 32'(p));
			rd(IDX_DCTL);
			ck(rv[6:2] === 5'h15, "five reflections kept");
		end
		// Second echo of pair 0: amplitude and raw arrival time only.
		wr(IDX_DSEL, 32'h0000_0004);
		rd(IDX_DRES);
		ck(rv === 32'hFFE0_001F, "raw time and amplitude");
		xfault <= 1'h1;
		wr(IDX_DCTL, 32'h0000_0001);
		waitDiag();
		xfault <= 1'h0;
		wr(IDX_DSEL, 32'h0000_0000);
		rd(IDX_DCTL);
		ck(rv[6:2] === 5'h13, "cross caps reflections");
		wr(IDX_DSEL, 32'h0000_0014);
		rd(IDX_DRES);
		ck(rv === 32'hFFCC_0033, "cross location");
		$display("test diagnostics done");
	endtask : t_diag
	task automatic waitDrop(input int lim);
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (linkDrop !== 1'h1 && n < lim);
	endtask : waitDrop
	task automatic t_link;
		live <= 1'h1;
		descrLock <= 1'h1;
		pcsLinkOk <= 1'h1;
		cyc(300);
		ck(linkUp === 1'h1, "link up");
		ck(energyPresent === 1'h1, "energy seen");
		descrLock <= 1'h0;
		waitDrop(200);
		ck(n >= 28 && n <= 32, "normal window");
		descrLock <= 1'h1;
		wr(IDX_FAST, 32'h0000_0922);
		wr(IDX_BASE, 32'h0000_0080);
		cyc(5);
		ck(linkUp === 1'h1, "link back");
		ck(fastLinkModes === 2'h1, "fast modes at 1000M");
		speed1000 <= 1'h0;
		cyc(2);
		ck(fastLinkModes === 2'h2, "fast modes at 100M");
		speed1000 <= 1'h1;
		rxErr <= 1'h1;
		live <= 1'h0;
		waitDrop(3000);
		ck(n >= FAST_CYC - 3 && n <= FAST_CYC + 3, "fast window");
		cyc(2);
		ck(diagBusy === 1'h1, "auto run");
		waitDiag();
		ck(energyPresent === 1'h0, "line quiet");
		rxErr <= 1'h0;
		$display("test link done");
	endtask : t_link
	// Watchdog: the tests need about 15000 cycles.
	initial begin
		repeat (60000) @(posedge ref_clk);
		errorCnt++;
		results();
	end
	initial begin
		cyc(5);
		// Reset is released once; a part whose clock output feeds another
		// is reset in software, never by the pin.
		nrst <= 1'h1;
		cyc(2);
		t_reset();
		t_test();
		t_clk();
		t_diag();
		t_link();
		results();
	end
endmodule : tb_top
`default_nettype wire
